// ==== design/lcm_monitor.sv ====
// link error, contention and timeout monitor with wishbone registers
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Contract
// R1: misaligned end byte raises end sync error
// R2: error report carries end sync bit
// R3: discard command after end sync error
// R4: unknown escape entry waits stop, sets bit
// R5: both ends detect, peripheral alone reports
// R6: misaligned low-power end raises sync error
// R7: low-power sync error waits for stop
// R8: bad request sequence captures false control
// R9: false control ignores request until stop
// R10: host flags false control locally
// R11: simple links detect no escape errors
// R12: full links detect and report all
// R13: either contention fault sets contention bit
// R14: timer expiry sets peripheral timeout bit
// R15: peripheral owns receive and transmit timers
// R16: receive timer bounds high-speed receive
// R17: receive timeout waits stop, then flags
// R18: receive timeout is always provided
// R19: receive timer may use link clock
// R20: timers programmable, restart on mode entry
// R21: host transmit timer ends transfer cleanly
// R22: receive timeout shorter than host's
// R23: transmit timer bounds bus possession
// R24: transmit timeout drops to receive, waits
// R25: host receive timeout longer, drives stop
// R26: errors accumulate, clear once reported
module lcm_monitor
  import lcm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [lcm_pkg::LCM_ADR_W-1:0] i_wb_adr,
  input wire logic [lcm_pkg::LCM_DAT_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [lcm_pkg::LCM_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_link_clk,
  input wire logic [1:0] i_lane_lp,
  input wire logic i_highspeed_receive_mode_active,
  input wire logic i_hs_eot,
  input wire logic i_hs_eot_misaligned,
  input wire logic i_esc_entry,
  input wire logic i_esc_cmd_known,
  input wire logic i_lowpower_receive_mode_end,
  input wire logic i_lowpower_receive_mode_misaligned,
  input wire logic i_lp_tx_active,
  input wire logic i_fault_lp_high,
  input wire logic i_fault_lp_low,
  input wire logic i_report_done,
  output logic [lcm_pkg::LCM_ERR_W-1:0] o_err_bits,
  output logic o_ack_with_error,
  output logic o_cmd_discard,
  output logic o_wait_stop,
  output logic o_highspeed_receive_mode_release,
  output logic o_lp_tx_release
);
  import lcm_pkg::*;

  logic [1:0] lane_s1_q, lane_s2_q, lane_prev_q;
  logic lclk_s1_q, lclk_s2_q, lclk_s3_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [LCM_LIM_W-1:0] hs_lim_q, lp_lim_q, hs_cnt_q, lp_cnt_q;
  logic hs_act_q, lp_act_q;
  lcm_state_e state_q;
  logic [1:0] pend_q;
  logic [LCM_ERR_W-1:0] err_q, set_v;
  logic run, hs_entry, lp_entry, hs_tick, hs_fire, lp_fire;
  logic end_sync, esc_err, lp_sync, false_ctrl, contention;
  logic enter_wait, leave_wait, wb_req;

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // address decode shared by write and read paths
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction

  // two-flop synchronisers for lane levels and the link clock
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lane_s1_q <= LANE_STOP;
      lane_s2_q <= LANE_STOP;
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
    end else if (i_ce) begin
      lane_s1_q <= i_lane_lp;
      lane_s2_q <= lane_s1_q;
      lclk_s1_q <= i_link_clk;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
    end
  end

  // event detection; all but contention only while not waiting for stop
  // R5: this end detects escape and sync errors
  // R11: simple links would gate these detectors off
  // R12: full link detects and reports all errors
  always_comb begin
    run = (state_q == LCM_RUN);
    hs_entry = i_highspeed_receive_mode_active & ~hs_act_q;
    lp_entry = i_lp_tx_active & ~lp_act_q;
    hs_tick = ctrl_q[CTRL_HS_LINKCLK] ? (lclk_s2_q & ~lclk_s3_q) : 1'b1;
    end_sync = run & i_hs_eot & i_hs_eot_misaligned;
    esc_err = run & i_esc_entry & ~i_esc_cmd_known;
    lp_sync = run & i_lowpower_receive_mode_end & i_lowpower_receive_mode_misaligned;
    false_ctrl = run & ~i_highspeed_receive_mode_active & ~i_lp_tx_active & (lane_s2_q != lane_prev_q)
                 & ((lane_prev_q == LANE_LP_REQ) | (lane_prev_q == LANE_HS_REQ))
                 & (lane_s2_q != LANE_BRIDGE);
    contention = i_fault_lp_high | i_fault_lp_low;
    hs_fire = run & ctrl_q[CTRL_HS_EN] & i_highspeed_receive_mode_active & ~hs_entry & ~i_hs_eot
              & (hs_cnt_q == hs_lim_q);
    lp_fire = run & ctrl_q[CTRL_LP_EN] & i_lp_tx_active & ~lp_entry & (lp_cnt_q == lp_lim_q);
    enter_wait = esc_err | lp_sync | false_ctrl | hs_fire | lp_fire;
    leave_wait = (state_q == LCM_WAIT) & (lane_s2_q == LANE_STOP);
  end

  // R16: high-speed receive timer, restarts on each entry
  // R15: peripheral holds receive and transmit timers
  // R18: receive timer enabled out of reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hs_cnt_q <= '0;
      hs_act_q <= 1'b0;
    end else if (i_ce) begin
      hs_act_q <= i_highspeed_receive_mode_active;
      // R19: tick on rising link clock edges or local clock
      if (!i_highspeed_receive_mode_active || hs_entry) begin
        hs_cnt_q <= '0;
      end else if (hs_tick && hs_cnt_q != hs_lim_q) begin
        hs_cnt_q <= hs_cnt_q + 1'b1;
      end
    end
  end

  // R23: low-power transmit possession timer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lp_cnt_q <= '0;
      lp_act_q <= 1'b0;
    end else if (i_ce) begin
      lp_act_q <= i_lp_tx_active;
      if (!i_lp_tx_active || lp_entry) begin
        lp_cnt_q <= '0;
      end else if (lp_cnt_q != lp_lim_q) begin
        lp_cnt_q <= lp_cnt_q + 1'b1;
      end
    end
  end

  // R9: wait in low-power receive until stop is seen
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= LCM_RUN;
      o_wait_stop <= 1'b0;
      lane_prev_q <= LANE_STOP;
    end else if (i_ce) begin
      lane_prev_q <= lane_s2_q;
      case (state_q)
        LCM_RUN: begin
          if (enter_wait) begin
            state_q <= LCM_WAIT;
            o_wait_stop <= 1'b1;
          end
        end
        LCM_WAIT: begin
          if (leave_wait) begin
            state_q <= LCM_RUN;
            o_wait_stop <= 1'b0;
          end
        end
        default: begin
          state_q <= LCM_RUN;
          o_wait_stop <= 1'b0;
        end
      endcase
    end
  end

  // errors held back until stop is observed
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= '0;
    end else if (i_ce) begin
      if (leave_wait) begin
        pend_q <= '0;
      end else begin
        pend_q <= pend_q | {hs_fire, esc_err};
      end
    end
  end

  // set vector of all error sources
  always_comb begin
    set_v = '0;
    // R1: misaligned end of high-speed receive
    set_v[ERR_END_SYNC] = end_sync;
    // R4: unknown escape entry committed at stop
    set_v[ERR_ESC_ENTRY] = leave_wait & pend_q[0];
    // R6: misaligned end of low-power receive
    set_v[ERR_LP_SYNC] = lp_sync;
    // R8: request not followed by bridge
    set_v[ERR_FALSE_CTRL] = false_ctrl;
    // R13: either contention fault
    set_v[ERR_CONTENTION] = contention;
    // R14: transmit expiry now, receive expiry at stop
    set_v[ERR_PERIPH_TO] = lp_fire | (leave_wait & pend_q[1]);
  end

  // R26: accumulate until reported, new events win over clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      err_q <= '0;
      o_ack_with_error <= 1'b0;
    end else if (i_ce) begin
      err_q <= (i_report_done ? '0 : err_q) | set_v;
      // R2: report packet requested whenever any bit is set
      o_ack_with_error <= |((i_report_done ? '0 : err_q) | set_v);
    end
  end
  assign o_err_bits = err_q;

  // one-cycle strobes to the lane and protocol side
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_discard <= 1'b0;
      o_highspeed_receive_mode_release <= 1'b0;
      o_lp_tx_release <= 1'b0;
    end else if (i_ce) begin
      // R3: tell the protocol side to drop the command
      o_cmd_discard <= end_sync;
      // R17: drop high-speed receive on timeout
      o_highspeed_receive_mode_release <= hs_fire;
      // R24: give up the bus on transmit timeout
      o_lp_tx_release <= lp_fire;
    end
  end

  // wishbone slave: ack one cycle after request, then drop
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      if (wb_req) begin
        o_wb_dat <= '0;
        if (reg_hit(i_wb_adr, REG_CTRL)) begin
          o_wb_dat[CTRL_W-1:0] <= ctrl_q;
        end else if (reg_hit(i_wb_adr, REG_HS_LIMIT)) begin
          o_wb_dat[LCM_LIM_W-1:0] <= hs_lim_q;
        end else if (reg_hit(i_wb_adr, REG_LP_LIMIT)) begin
          o_wb_dat[LCM_LIM_W-1:0] <= lp_lim_q;
        end else if (reg_hit(i_wb_adr, REG_ERR)) begin
          o_wb_dat[LCM_ERR_W-1:0] <= err_q;
        end else if (reg_hit(i_wb_adr, REG_STATE)) begin
          o_wb_dat[ST_WAIT] <= o_wait_stop;
          o_wb_dat[ST_HS_ACT] <= i_highspeed_receive_mode_active;
          o_wb_dat[ST_PEND_ESC] <= pend_q[0];
          o_wb_dat[ST_PEND_TO] <= pend_q[1];
        end
      end
    end
  end

  // R20: programmable terminal counts and enables
  // R22: receive limit set below host transmit limit
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RST;
      hs_lim_q <= HS_LIMIT_RST;
      lp_lim_q <= LP_LIMIT_RST;
    end else if (i_ce && wb_req && i_wb_we) begin
      if (reg_hit(i_wb_adr, REG_CTRL)) begin
        ctrl_q <= CTRL_W'(wmerge(32'(ctrl_q), i_wb_dat, i_wb_sel));
      end
      if (reg_hit(i_wb_adr, REG_HS_LIMIT)) begin
        hs_lim_q <= LCM_LIM_W'(wmerge(32'(hs_lim_q), i_wb_dat, i_wb_sel));
      end
      if (reg_hit(i_wb_adr, REG_LP_LIMIT)) begin
        lp_lim_q <= LCM_LIM_W'(wmerge(32'(lp_lim_q), i_wb_dat, i_wb_sel));
      end
    end
  end

  end_sync_a: assert property (@(posedge i_clock) disable iff (i_rst) // R1
    i_ce && end_sync |=> err_q[ERR_END_SYNC] && o_cmd_discard && o_ack_with_error)
    else $error("end sync error not flagged");
  esc_wait_a: assert property (@(posedge i_clock) disable iff (i_rst) // R4
    i_ce && esc_err |=> o_wait_stop && pend_q[0])
    else $error("escape entry error not held to stop");
  lp_sync_a: assert property (@(posedge i_clock) disable iff (i_rst) // R7
    i_ce && lp_sync |=> err_q[ERR_LP_SYNC] && o_wait_stop)
    else $error("low-power sync error not handled");
  false_ctrl_a: assert property (@(posedge i_clock) disable iff (i_rst) // R8
    i_ce && run && !i_highspeed_receive_mode_active && !i_lp_tx_active && lane_prev_q == LANE_HS_REQ
    && lane_s2_q == LANE_STOP |=> err_q[ERR_FALSE_CTRL] && o_wait_stop)
    else $error("false control not captured");
  wait_hold_a: assert property (@(posedge i_clock) disable iff (i_rst) // R9
    i_ce && o_wait_stop && lane_s2_q != LANE_STOP |=> o_wait_stop)
    else $error("left stop wait without stop state");
  contention_a: assert property (@(posedge i_clock) disable iff (i_rst) // R13
    i_ce && (i_fault_lp_high || i_fault_lp_low) |=> err_q[ERR_CONTENTION])
    else $error("contention bit not set");
  hs_timeout_a: assert property (@(posedge i_clock) disable iff (i_rst) // R17
    i_ce && hs_fire |=> o_highspeed_receive_mode_release && o_wait_stop && pend_q[1])
    else $error("receive timeout not handled");
  lp_timeout_a: assert property (@(posedge i_clock) disable iff (i_rst) // R24
    i_ce && lp_fire |=> o_lp_tx_release && o_wait_stop && err_q[ERR_PERIPH_TO])
    else $error("transmit timeout not handled");
  timer_restart_a: assert property (@(posedge i_clock) disable iff (i_rst) // R20
    i_ce && hs_entry |=> hs_cnt_q == '0)
    else $error("receive timer did not restart");
  report_clear_a: assert property (@(posedge i_clock) disable iff (i_rst) // R26
    i_ce && i_report_done && set_v == '0 |=> err_q == '0 && !o_ack_with_error)
    else $error("error register not cleared after report");

  // pulses, commits and counters that the tests seldom reach
  discard_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst) // R3
    i_ce && !end_sync |=> !o_cmd_discard)
    else $error("discard strobe without end sync error");
  ack_error_a: assert property (@(posedge i_clock) disable iff (i_rst) // R2
    i_ce && set_v != '0 |=> o_ack_with_error)
    else $error("error report not requested");
  esc_commit_a: assert property (@(posedge i_clock) disable iff (i_rst) // R4
    i_ce && leave_wait && pend_q[0] |=> err_q[ERR_ESC_ENTRY] && !o_wait_stop)
    else $error("escape entry bit not committed at stop");
  hs_commit_a: assert property (@(posedge i_clock) disable iff (i_rst) // R14
    i_ce && leave_wait && pend_q[1] |=> err_q[ERR_PERIPH_TO])
    else $error("receive timeout bit not committed at stop");
  hs_idle_clear_a: assert property (@(posedge i_clock) disable iff (i_rst) // R16
    i_ce && !i_highspeed_receive_mode_active |=> hs_cnt_q == '0)
    else $error("receive timer runs outside high-speed receive");
  lp_restart_a: assert property (@(posedge i_clock) disable iff (i_rst) // R23
    i_ce && lp_entry |=> lp_cnt_q == '0)
    else $error("transmit timer did not restart");
  hs_release_a: assert property (@(posedge i_clock) disable iff (i_rst) // R17
    i_ce && !hs_fire |=> !o_highspeed_receive_mode_release)
    else $error("receive release without timeout");
  lp_release_a: assert property (@(posedge i_clock) disable iff (i_rst) // R24
    i_ce && !lp_fire |=> !o_lp_tx_release)
    else $error("transmit release without timeout");
  err_keep_a: assert property (@(posedge i_clock) disable iff (i_rst) // R26
    i_ce && !i_report_done |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error bit lost before report");
  wb_ack_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst) // R20
    i_ce && o_wb_ack |=> !o_wb_ack)
    else $error("bus acknowledge held longer than one cycle");
endmodule

// ==== design/lcm_pkg.sv ====
// constants for the link error and contention monitor
package lcm_pkg;
  localparam int unsigned LCM_ADR_W = 8;
  localparam int unsigned LCM_DAT_W = 32;
  localparam int unsigned LCM_LIM_W = 24;
  localparam int unsigned LCM_ERR_W = 6;
  // error report bit positions
  localparam int unsigned ERR_END_SYNC = 0;
  localparam int unsigned ERR_ESC_ENTRY = 1;
  localparam int unsigned ERR_LP_SYNC = 2;
  localparam int unsigned ERR_FALSE_CTRL = 3;
  localparam int unsigned ERR_CONTENTION = 4;
  localparam int unsigned ERR_PERIPH_TO = 5;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_HS_LIMIT = 8'h04;
  localparam logic [7:0] REG_LP_LIMIT = 8'h08;
  localparam logic [7:0] REG_ERR = 8'h0C;
  localparam logic [7:0] REG_STATE = 8'h10;
  // control bits and reset values
  localparam int unsigned CTRL_HS_EN = 0;
  localparam int unsigned CTRL_LP_EN = 1;
  localparam int unsigned CTRL_HS_LINKCLK = 2;
  localparam int unsigned CTRL_W = 3;
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam logic [23:0] HS_LIMIT_RST = 24'h00FFFF;
  localparam logic [23:0] LP_LIMIT_RST = 24'h000FFF;
  // status bits
  localparam int unsigned ST_WAIT = 0;
  localparam int unsigned ST_HS_ACT = 1;
  localparam int unsigned ST_PEND_ESC = 2;
  localparam int unsigned ST_PEND_TO = 3;
  // lane line states, {dp, dn}
  localparam logic [1:0] LANE_STOP = 2'h3;
  localparam logic [1:0] LANE_LP_REQ = 2'h2;
  localparam logic [1:0] LANE_HS_REQ = 2'h1;
  localparam logic [1:0] LANE_BRIDGE = 2'h0;
  typedef enum logic {LCM_RUN, LCM_WAIT} lcm_state_e;
endpackage

// ==== sim/lcm_host_model.sv ====
// host-side lane driver and link clock source for the monitor bench
`timescale 1ns/1ps
module lcm_host_model (
  input wire logic i_clock,
  output logic [1:0] o_lane,
  output logic o_link_clk
);
  import lcm_pkg::*;
  logic run_q;
  int false_seen = 0;
  // link clock toggles only inside a frame, otherwise stands low
  initial begin
    o_lane = LANE_STOP;
    o_link_clk = 1'b0;
    run_q = 1'b0;
    #3;
    forever #80 o_link_clk = run_q & ~o_link_clk;
  end
  // lane levels change just after a clock edge
  task set_lane(input logic [1:0] v);
    @(posedge i_clock);
    // host flags a request not followed by bridge
    if ((o_lane == LANE_LP_REQ || o_lane == LANE_HS_REQ) && v != LANE_BRIDGE) false_seen++;
    o_lane <= v;
  endtask
  task frame(input logic [1:0] v, input int k, input logic clk_on);
    set_lane(v);
    run_q = clk_on;
    repeat (k) @(posedge i_clock);
    run_q = 1'b0;
    set_lane(LANE_STOP);
  endtask
endmodule

// ==== sim/tb_lcm_monitor.sv ====
// self-checking bench for the link error and contention monitor
`timescale 1ns/1ps
module tb_lcm_monitor;
  import lcm_pkg::*;
  logic i_clock, i_rst, cyc, we, hs_act, lp_act, known, eot_mis, lp_mis;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd;
  logic [5:0] ev_q, o_err_bits;
  logic [LCM_DAT_W-1:0] o_wb_dat;
  logic o_wb_ack, o_ack_with_error, o_cmd_discard, o_wait_stop;
  logic o_highspeed_receive_mode_release, o_lp_tx_release, link_clk;
  logic [1:0] lane;
  int fail_count = 0, compares = 0, cycles = 0, n_hs = 0, n = 0;

  lcm_monitor lcm_monitor_i (.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_link_clk(link_clk),
    .i_lane_lp(lane), .i_highspeed_receive_mode_active(hs_act), .i_hs_eot(ev_q[0]),
    .i_hs_eot_misaligned(eot_mis), .i_esc_entry(ev_q[1]), .i_esc_cmd_known(known),
    .i_lowpower_receive_mode_end(ev_q[2]), .i_lowpower_receive_mode_misaligned(lp_mis), .i_lp_tx_active(lp_act),
    .i_fault_lp_high(ev_q[3]), .i_fault_lp_low(ev_q[4]), .i_report_done(ev_q[5]),
    .o_err_bits(o_err_bits), .o_ack_with_error(o_ack_with_error),
    .o_cmd_discard(o_cmd_discard), .o_wait_stop(o_wait_stop),
    .o_highspeed_receive_mode_release(o_highspeed_receive_mode_release), .o_lp_tx_release(o_lp_tx_release));
  lcm_host_model lcm_host_model_i (.i_clock(i_clock), .o_lane(lane), .o_link_clk(link_clk));

  // system clock, 8 ns
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // release strobe counter and run ceiling
  always @(posedge i_clock) begin
    cycles++;
    if (o_highspeed_receive_mode_release === 1'b1) n_hs++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge i_clock);
  endtask
  // classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clock);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 50);
    rd = o_wb_dat;
    if (t >= 50) fail_count++;
    cyc <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
    wb(1'b0, a, 32'h0);
    check(rd, exp, m);
  endtask
  // one-cycle event pulse, sampled one cycle after it is taken
  task ev(input logic [5:0] v);
    @(posedge i_clock);
    ev_q <= v;
    @(posedge i_clock);
    ev_q <= 6'h00;
    @(posedge i_clock);
  endtask
  task wait_rel(input logic lp);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while ((lp ? o_lp_tx_release : o_highspeed_receive_mode_release) !== 1'b1 && n < 1000);
  endtask
  // timer run with the host holding the lane, checks at the strobe
  task timer_run(input logic lp, input int k, input logic clk_on, input int lo, input int hi);
    fork
      lcm_host_model_i.frame(LANE_BRIDGE, k, clk_on);
      begin
        step(4);
        if (lp) lp_act <= 1'b1;
        else hs_act <= 1'b1;
        wait_rel(lp);
        check(n >= lo && n <= hi, 1'b1, "timer length");
        check(o_wait_stop, 1'b1, "wait at expiry");
        check(o_err_bits, lp ? 6'h20 : 6'h00, "bit at expiry");
        hs_act <= 1'b0;
        lp_act <= 1'b0;
      end
    join
    step(5);
    check(o_wait_stop, 1'b0, "wait after stop");
    check(o_err_bits, 6'h20, "timeout bit");
    ev(6'h20);
  endtask

  initial begin
    {i_rst, cyc, we, adr, wdat, sel} = {1'b1, 1'b0, 1'b0, 8'h00, 32'h0, 4'hF};
    {hs_act, lp_act, known, eot_mis, lp_mis, ev_q} = '0;
    step(16);
    i_rst <= 1'b0;
    rd_chk(REG_CTRL, 32'h3, "ctrl reset");
    rd_chk(REG_HS_LIMIT, 32'h0000FFFF, "hs limit reset");
    rd_chk(REG_LP_LIMIT, 32'h00000FFF, "lp limit reset");
    wb(1'b1, REG_ERR, 32'h3F);
    rd_chk(REG_ERR, 32'h0, "err read only");
    rd_chk(8'h40, 32'h0, "unmapped");
    wb(1'b1, REG_HS_LIMIT, 32'hAB000008);
    rd_chk(REG_HS_LIMIT, 32'h8, "limit width");
    wb(1'b1, REG_LP_LIMIT, 32'h8);
    // clean then misaligned end of transmission
    ev(6'h01);
    check(o_cmd_discard, 1'b0, "clean end");
    eot_mis <= 1'b1;
    ev(6'h01);
    check(o_err_bits, 6'h01, "end sync");
    check(o_cmd_discard, 1'b1, "discard");
    check(o_ack_with_error, 1'b1, "ack with error");
    eot_mis <= 1'b0;
    // contention accumulates, set wins over clear
    ev(6'h08);
    check(o_err_bits, 6'h11, "accumulate");
    rd_chk(REG_ERR, 32'h11, "err readback");
    ev(6'h30);
    check(o_err_bits, 6'h10, "set wins");
    ev(6'h20);
    check(o_ack_with_error, 1'b0, "cleared");
    // unknown escape entry waits for stop
    lcm_host_model_i.set_lane(LANE_BRIDGE);
    ev(6'h02);
    check(o_wait_stop, 1'b1, "escape wait");
    check(o_err_bits, 6'h00, "escape bit late");
    rd_chk(REG_STATE, 32'h5, "state in wait");
    eot_mis <= 1'b1;
    ev(6'h09);
    eot_mis <= 1'b0;
    check(o_err_bits, 6'h10, "ignored in wait");
    lcm_host_model_i.set_lane(LANE_STOP);
    step(5);
    check(o_wait_stop, 1'b0, "escape done");
    check(o_err_bits, 6'h12, "escape bit");
    ev(6'h20);
    // known escape then misaligned low-power end
    lcm_host_model_i.set_lane(LANE_BRIDGE);
    known <= 1'b1;
    ev(6'h02);
    check(o_wait_stop, 1'b0, "known escape");
    known <= 1'b0;
    lp_mis <= 1'b1;
    ev(6'h04);
    lp_mis <= 1'b0;
    check(o_err_bits, 6'h04, "lp sync");
    check(o_wait_stop, 1'b1, "lp sync wait");
    lcm_host_model_i.set_lane(LANE_STOP);
    step(5);
    check(o_wait_stop, 1'b0, "lp sync done");
    ev(6'h20);
    // request not followed by bridge
    lcm_host_model_i.set_lane(LANE_LP_REQ);
    lcm_host_model_i.set_lane(LANE_HS_REQ);
    step(4);
    check(o_wait_stop, 1'b1, "false control wait");
    lcm_host_model_i.set_lane(LANE_STOP);
    step(5);
    check(o_err_bits, 6'h08, "false control");
    ev(6'h20);
    lcm_host_model_i.set_lane(LANE_HS_REQ);
    lcm_host_model_i.set_lane(LANE_BRIDGE);
    lcm_host_model_i.set_lane(LANE_STOP);
    step(5);
    check(o_err_bits, 6'h00, "valid request");
    check(lcm_host_model_i.false_seen, 2, "host flag");
    // leaving receive after end of transmission, before the limit, clears the timer
    @(posedge i_clock);
    hs_act <= 1'b1;
    ev(6'h01);
    hs_act <= 1'b0;
    step(12);
    check(n_hs, 0, "no early fire");
    timer_run(1'b0, 40, 1'b0, 8, 13);
    wb(1'b1, REG_CTRL, 32'h7);
    wb(1'b1, REG_HS_LIMIT, 32'h4);
    timer_run(1'b0, 250, 1'b1, 60, 140);
    timer_run(1'b1, 40, 1'b0, 8, 13);
    stop_test();
  end
endmodule
